// *** ext_edge_detect.v ***
// Edge detector for one external interrupt pin with selectable polarity.
// Assumes the pin is already synchronous to pclk.
`timescale 1ns/1ps

module ext_edge_detect (
	input wire pclk,
	input wire presetn,
	input wire pin,
	input wire falling_sel,
	output reg edge_ff
);

reg pin_d_ff;

////////////////////////////////////////////////////////////////////////////////
// Previous pin level and one-cycle edge pulse
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pin_d_ff <= 1'b0;
		edge_ff <= 1'b0;
	end else begin
		pin_d_ff <= pin;
		// Polarity 1 catches the falling edge, 0 the rising one
		edge_ff <= falling_sel ? (pin_d_ff & ~pin) : (pin & ~pin_d_ff);
	end
end

endmodule

// *** vectored_interrupt_controller.v ***
// Priority-based vectored interrupt controller with APB register access.
// Assumes request pulses, trap pulses and pins synchronous to pclk and a core that
// acknowledges the offered vector with a one-cycle pulse.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps

`include "vic_regs.vh"

// How it works
// - Each source has a flag set by its peripheral or pin; only software clears.
// - A source with its enable clear never interrupts, though its flag may set.
// - Each source has a three-bit software priority selecting one of eight levels.
// - Flag, enable and priority bits follow natural order; vector 8 uses bit 0.
// - Pending vector number and new level latch into the pending status register.
// - Latched new level equals the pending interrupt's priority, coded 0 to 7.
// - Vector numbers are direct: source vectors from 8, math trap 4, soft trap 6.
// - Current level joins the core level-high bit above the three status level bits.
// - User interrupts are blocked when level bits are 111 or level-high is set.
// - Software writes the level bits except while nesting disable is set.
// - Level-high bit resets to 0 and software can never set it.
// - Control one bit 15 disables nesting when 1, resetting to 0.
// - Control one holds math, address, stack and clock failure trap flags.
// - Control two bit 15 is global enable, reset 1; 0 blocks user interrupts only.
// - Control two bit 14 reads 1 while the temporary disable instruction runs.
// - Control two bit 13 is a software trap bit; writing 1 raises a trap.
// - Control two bit 8 selects the alternate vector table, resetting to 0.
// - Control two bits 4..0 pick falling (1) or rising (0) edge per external pin.
// - Control four flags double-bit error and soft hard trap; software clears.
module vectored_interrupt_controller (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_ff,
	output reg pready_ff,
	output reg pslverr_ff,
	input wire [127:0] periph_irq,
	input wire [4:0] ext_irq_pin,
	input wire math_fault_evt,
	input wire address_fault_evt,
	input wire stack_fault_evt,
	input wire clock_failure_evt,
	input wire double_bit_error_evt,
	input wire temp_disable_active,
	input wire cpu_ack,
	output reg irq_req_ff,
	output reg [7:0] irq_vector_ff,
	output reg [3:0] irq_level_ff,
	output reg trap_req_ff,
	output reg [7:0] trap_vector_ff,
	output reg alt_table_ff
);

////////////////////////////////////////////////////////////////////////////////
// State
reg [`NUM_SRC-1:0] flag_ff;
reg [`NUM_SRC-1:0] enable_ff;
reg [`NUM_SRC*`PRIO_W-1:0] prio_ff;
reg [2:0] cpu_priority_level_ff;
reg cpu_level_high_bit_ff;
reg nesting_disable_ff;
reg math_fault_flag_ff;
reg address_fault_flag_ff;
reg stack_fault_flag_ff;
reg clock_failure_flag_ff;
reg global_irq_enable_ff;
reg software_trap_ff;
reg [4:0] ext_polarity_ff;
reg double_bit_error_flag_ff;
reg soft_hard_trap_flag_ff;
reg vector_hold_ff;
reg unacked_request_ff;
reg [7:0] pending_vector_field_ff;
reg [3:0] new_level_field_ff;
reg [7:0] acked_vector_ff;
reg [3:0] acked_level_ff;

wire [4:0] ext_edge;
wire apb_write;
wire apb_setup;
wire [3:0] cur_level;
wire user_blocked;
wire [`NUM_SRC-1:0] flag_set;

////////////////////////////////////////////////////////////////////////////////
// Decode helpers

// Range hit test for a word-aligned array region starting at base
function in_region;
	input [11:0] addr;
	input [11:0] base;
	input [11:0] words;
	begin
		in_region = (addr >= base) && (addr < base + {words[9:0], 2'b00}) &&
			(addr[1:0] == 2'b00);
	end
endfunction

// Word index of an address inside a region
function [4:0] word_idx;
	input [11:0] addr;
	input [11:0] base;
	reg [11:0] diff;
	begin
		diff = addr - base;
		word_idx = diff[6:2];
	end
endfunction

// Priority of one source
function [2:0] prio_of;
	input [`NUM_SRC*`PRIO_W-1:0] all;
	input integer idx;
	begin
		prio_of = all[idx*`PRIO_W +: `PRIO_W];
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// External pins: edge detection and mapping onto their sources
genvar g;
generate
	for (g = 0; g < `NUM_EXT; g = g + 1) begin : g_ext
		ext_edge_detect u_edge (
			.pclk(pclk),
			.presetn(presetn),
			.pin(ext_irq_pin[g]),
			.falling_sel(ext_polarity_ff[g]),
			.edge_ff(ext_edge[g])
		);
	end
endgenerate

// Request pulses from peripherals and pins merged per source
reg [`NUM_SRC-1:0] ext_set;
reg [34:0] ext_map;
integer e;
always @* begin
	ext_set = {`NUM_SRC{1'b0}};
	ext_map = `EXT_IRQ_MAP;
	for (e = 0; e < `NUM_EXT; e = e + 1)
		ext_set[ext_map[e*`SRC_IDX_W +: `SRC_IDX_W]] = ext_edge[e];
end
assign flag_set = periph_irq | ext_set;

////////////////////////////////////////////////////////////////////////////////
// Arbitration
assign cur_level = {cpu_level_high_bit_ff, cpu_priority_level_ff};
assign user_blocked = (cpu_priority_level_ff == `LVL_USER_BLOCK) ||
	cpu_level_high_bit_ff || !global_irq_enable_ff;

reg win_found;
reg [6:0] win_idx;
reg [2:0] win_prio;
reg held_off;
integer i;
// Strict greater-than keeps the lower natural order on ties
always @* begin
	win_found = 1'b0;
	win_idx = 7'h00;
	win_prio = `RST_PRIO;
	held_off = 1'b0;
	for (i = 0; i < `NUM_SRC; i = i + 1) begin
		if (flag_ff[i] && enable_ff[i]) begin
			if ({1'b0, prio_of(prio_ff, i)} > cur_level && !user_blocked) begin
				if (!win_found || prio_of(prio_ff, i) > win_prio) begin
					win_found = 1'b1;
					win_idx = i[6:0];
					win_prio = prio_of(prio_ff, i);
				end
			end else if (prio_of(prio_ff, i) != `RST_PRIO) begin
				held_off = 1'b1;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// APB slave: one wait-free access phase, read data captured in setup
assign apb_setup = psel && !penable;
assign apb_write = psel && penable && pready_ff && pwrite;

// Offset decode for reads and unmapped detection
reg [31:0] rd_mux;
reg rd_hit;
reg [4:0] widx;
always @* begin
	rd_mux = 32'h0000_0000;
	rd_hit = 1'b1;
	widx = 5'h00;
	if (in_region(paddr, `OFF_FLAG_BASE, `NUM_FLAG_WORDS)) begin
		widx = word_idx(paddr, `OFF_FLAG_BASE);
		rd_mux[15:0] = flag_ff[widx[2:0]*`SRC_PER_WORD +: `SRC_PER_WORD];
	end else if (in_region(paddr, `OFF_ENABLE_BASE, `NUM_FLAG_WORDS)) begin
		widx = word_idx(paddr, `OFF_ENABLE_BASE);
		rd_mux[15:0] = enable_ff[widx[2:0]*`SRC_PER_WORD +: `SRC_PER_WORD];
	end else if (in_region(paddr, `OFF_PRIO_BASE, `NUM_PRIO_WORDS)) begin
		widx = word_idx(paddr, `OFF_PRIO_BASE);
		rd_mux[15:0] = {1'b0, prio_of(prio_ff, widx*4+3), 1'b0, prio_of(prio_ff, widx*4+2),
			1'b0, prio_of(prio_ff, widx*4+1), 1'b0, prio_of(prio_ff, widx*4)};
	end else begin
		case (paddr)
			`OFF_CPU_ALU_STATUS:
				rd_mux[`SR_LVL_MSB:`SR_LVL_LSB] = cpu_priority_level_ff;
			`OFF_CPU_CORE_CONTROL:
				rd_mux[`CORE_LVL_HIGH_BIT] = cpu_level_high_bit_ff;
			`OFF_IRQ_CONTROL_ONE: begin
				rd_mux[`C1_NESTING_DISABLE] = nesting_disable_ff;
				rd_mux[`C1_MATH_FAULT] = math_fault_flag_ff;
				rd_mux[`C1_ADDRESS_FAULT] = address_fault_flag_ff;
				rd_mux[`C1_STACK_FAULT] = stack_fault_flag_ff;
				rd_mux[`C1_CLOCK_FAILURE] = clock_failure_flag_ff;
			end
			`OFF_IRQ_CONTROL_TWO: begin
				rd_mux[`C2_GLOBAL_ENABLE] = global_irq_enable_ff;
				rd_mux[`C2_TEMP_DISABLE] = temp_disable_active;
				rd_mux[`C2_SOFTWARE_TRAP] = software_trap_ff;
				rd_mux[`C2_ALT_TABLE] = alt_table_ff;
				rd_mux[`C2_POLARITY_MSB:0] = ext_polarity_ff;
			end
			`OFF_IRQ_CONTROL_FOUR: begin
				rd_mux[`C4_DOUBLE_BIT_ERROR] = double_bit_error_flag_ff;
				rd_mux[`C4_SOFT_HARD_TRAP] = soft_hard_trap_flag_ff;
			end
			`OFF_PENDING_VECTOR_STATUS: begin
				rd_mux[`PV_UNACKED] = unacked_request_ff;
				rd_mux[`PV_VECTOR_HOLD] = vector_hold_ff;
				rd_mux[`PV_LEVEL_LSB+3:`PV_LEVEL_LSB] = new_level_field_ff;
				rd_mux[7:0] = pending_vector_field_ff;
			end
			default: rd_hit = 1'b0;
		endcase
	end
end

// Handshake and read data
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready_ff <= 1'b0;
		pslverr_ff <= 1'b0;
		prdata_ff <= 32'h0000_0000;
	end else begin
		pready_ff <= apb_setup;
		if (apb_setup) begin
			pslverr_ff <= !rd_hit;
			prdata_ff <= rd_hit ? rd_mux : 32'h0000_0000;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Per-source flag, enable and priority storage
wire wr_flag = apb_write && in_region(paddr, `OFF_FLAG_BASE, `NUM_FLAG_WORDS);
wire wr_en = apb_write && in_region(paddr, `OFF_ENABLE_BASE, `NUM_FLAG_WORDS);
wire wr_prio = apb_write && in_region(paddr, `OFF_PRIO_BASE, `NUM_PRIO_WORDS);

integer s;
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		flag_ff <= {`NUM_SRC{1'b0}};
		enable_ff <= {`NUM_SRC{1'b0}};
		for (s = 0; s < `NUM_SRC; s = s + 1)
			prio_ff[s*`PRIO_W +: `PRIO_W] <= `RST_PRIO;
	end else begin
		for (s = 0; s < `NUM_SRC; s = s + 1) begin
			// Software writes 0 to clear only; a set in the same cycle wins
			if (wr_flag && widx[2:0] == s / `SRC_PER_WORD)
				flag_ff[s] <= (flag_ff[s] & pwdata[s % `SRC_PER_WORD]) | flag_set[s];
			else
				flag_ff[s] <= flag_ff[s] | flag_set[s];
			if (wr_en && widx[2:0] == s / `SRC_PER_WORD)
				enable_ff[s] <= pwdata[s % `SRC_PER_WORD];
			if (wr_prio && widx == s / `SRC_PER_PRIO_WORD)
				prio_ff[s*`PRIO_W +: `PRIO_W] <=
					pwdata[(s % `SRC_PER_PRIO_WORD)*4 +: `PRIO_W];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control, level and trap registers
wire wr_sr = apb_write && paddr == `OFF_CPU_ALU_STATUS;
wire wr_core = apb_write && paddr == `OFF_CPU_CORE_CONTROL;
wire wr_c1 = apb_write && paddr == `OFF_IRQ_CONTROL_ONE;
wire wr_c2 = apb_write && paddr == `OFF_IRQ_CONTROL_TWO;
wire wr_c4 = apb_write && paddr == `OFF_IRQ_CONTROL_FOUR;
wire wr_pv = apb_write && paddr == `OFF_PENDING_VECTOR_STATUS;
wire any_trap_evt = math_fault_evt | address_fault_evt | stack_fault_evt |
	clock_failure_evt | double_bit_error_evt;
wire take_ack = cpu_ack && irq_req_ff;
wire software_trap_raise = wr_c2 && pwdata[`C2_SOFTWARE_TRAP];

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cpu_priority_level_ff <= `RST_LEVEL;
		cpu_level_high_bit_ff <= 1'b0;
		nesting_disable_ff <= 1'b0;
		math_fault_flag_ff <= 1'b0;
		address_fault_flag_ff <= 1'b0;
		stack_fault_flag_ff <= 1'b0;
		clock_failure_flag_ff <= 1'b0;
		global_irq_enable_ff <= `RST_GLOBAL_ENABLE;
		software_trap_ff <= 1'b0;
		alt_table_ff <= 1'b0;
		ext_polarity_ff <= 5'h00;
		double_bit_error_flag_ff <= 1'b0;
		soft_hard_trap_flag_ff <= 1'b0;
		vector_hold_ff <= 1'b0;
	end else begin
		// Acknowledge raises the level; with nesting off it jumps to 7
		if (take_ack)
			cpu_priority_level_ff <= nesting_disable_ff ? `LVL_USER_BLOCK : irq_level_ff[2:0];
		else if (wr_sr && !nesting_disable_ff)
			cpu_priority_level_ff <= pwdata[`SR_LVL_MSB:`SR_LVL_LSB];
		// Fault and double-bit error events lift the level above 7; software may only clear it
		if (any_trap_evt)
			cpu_level_high_bit_ff <= 1'b1;
		else if (wr_core && !pwdata[`CORE_LVL_HIGH_BIT])
			cpu_level_high_bit_ff <= 1'b0;
		if (wr_c1) begin
			nesting_disable_ff <= pwdata[`C1_NESTING_DISABLE];
			math_fault_flag_ff <= pwdata[`C1_MATH_FAULT] | math_fault_evt;
			address_fault_flag_ff <= pwdata[`C1_ADDRESS_FAULT] | address_fault_evt;
			stack_fault_flag_ff <= pwdata[`C1_STACK_FAULT] | stack_fault_evt;
			clock_failure_flag_ff <= pwdata[`C1_CLOCK_FAILURE] | clock_failure_evt;
		end else begin
			math_fault_flag_ff <= math_fault_flag_ff | math_fault_evt;
			address_fault_flag_ff <= address_fault_flag_ff | address_fault_evt;
			stack_fault_flag_ff <= stack_fault_flag_ff | stack_fault_evt;
			clock_failure_flag_ff <= clock_failure_flag_ff | clock_failure_evt;
		end
		if (wr_c2) begin
			global_irq_enable_ff <= pwdata[`C2_GLOBAL_ENABLE];
			software_trap_ff <= pwdata[`C2_SOFTWARE_TRAP];
			alt_table_ff <= pwdata[`C2_ALT_TABLE];
			ext_polarity_ff <= pwdata[`C2_POLARITY_MSB:0];
		end
		// Write 0 clears, events win over a clear in the same cycle
		if (wr_c4) begin
			double_bit_error_flag_ff <= (double_bit_error_flag_ff &
				pwdata[`C4_DOUBLE_BIT_ERROR]) | double_bit_error_evt;
			soft_hard_trap_flag_ff <= (soft_hard_trap_flag_ff &
				pwdata[`C4_SOFT_HARD_TRAP]) | software_trap_raise;
		end else begin
			double_bit_error_flag_ff <= double_bit_error_flag_ff | double_bit_error_evt;
			soft_hard_trap_flag_ff <= soft_hard_trap_flag_ff | software_trap_raise;
		end
		if (wr_pv)
			vector_hold_ff <= pwdata[`PV_VECTOR_HOLD];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Core-facing request, trap request and pending status
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		irq_req_ff <= 1'b0;
		irq_vector_ff <= `VEC_NONE;
		irq_level_ff <= 4'h0;
		trap_req_ff <= 1'b0;
		trap_vector_ff <= `VEC_NONE;
		unacked_request_ff <= 1'b0;
		pending_vector_field_ff <= `VEC_NONE;
		new_level_field_ff <= 4'h0;
		acked_vector_ff <= `VEC_NONE;
		acked_level_ff <= 4'h0;
	end else begin
		// Dropped for the cycle after an acknowledge while the level settles
		irq_req_ff <= win_found && !take_ack;
		irq_vector_ff <= `VEC_USER_BASE + {1'b0, win_idx};
		irq_level_ff <= {1'b0, win_prio};
		// Traps ignore the global enable and the level bits
		trap_req_ff <= math_fault_flag_ff | soft_hard_trap_flag_ff |
			double_bit_error_flag_ff | software_trap_ff;
		if (math_fault_flag_ff)
			trap_vector_ff <= `VEC_MATH_TRAP;
		else if (soft_hard_trap_flag_ff | double_bit_error_flag_ff | software_trap_ff)
			trap_vector_ff <= `VEC_SOFT_TRAP;
		else
			trap_vector_ff <= `VEC_NONE;
		unacked_request_ff <= held_off;
		if (take_ack) begin
			acked_vector_ff <= irq_vector_ff;
			acked_level_ff <= irq_level_ff;
		end
		if (vector_hold_ff) begin
			if (win_found) begin
				pending_vector_field_ff <= `VEC_USER_BASE + {1'b0, win_idx};
				new_level_field_ff <= {1'b0, win_prio};
			end
		end else begin
			pending_vector_field_ff <= take_ack ? irq_vector_ff : acked_vector_ff;
			new_level_field_ff <= take_ack ? irq_level_ff : acked_level_ff;
		end
	end
end

endmodule

// *** vectored_interrupt_controller_tb.sv ***
// Self-checking bench of the vectored interrupt controller.
// Assumes the APB map of vic_regs.vh and the core model on cpu_ack.
`timescale 1ns/1ps

module vectored_interrupt_controller_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] r;
	logic [127:0] periph_irq = '0;
	logic [4:0] ext_irq_pin = '0;
	logic [4:0] evt = '0;
	logic tda = 1'b0;
	logic ack_en = 1'b0;
	logic [3:0] ack_delay = 4'h0;
	logic [75:0] rows [14];
	wire [31:0] prdata_ff;
	wire pready_ff, pslverr_ff, cpu_ack, irq_req_ff, trap_req_ff, alt_table_ff;
	wire [7:0] irq_vector_ff;
	wire [7:0] trap_vector_ff;
	wire [3:0] irq_level_ff;
	int err_total = 0;
	int samples_checked = 0;
	int cyc = 0;

	vectored_interrupt_controller dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
		.pslverr_ff(pslverr_ff), .periph_irq(periph_irq), .ext_irq_pin(ext_irq_pin),
		.math_fault_evt(evt[4]), .address_fault_evt(evt[3]), .stack_fault_evt(evt[2]),
		.clock_failure_evt(evt[1]), .double_bit_error_evt(evt[0]),
		.temp_disable_active(tda), .cpu_ack(cpu_ack), .irq_req_ff(irq_req_ff),
		.irq_vector_ff(irq_vector_ff), .irq_level_ff(irq_level_ff),
		.trap_req_ff(trap_req_ff), .trap_vector_ff(trap_vector_ff),
		.alt_table_ff(alt_table_ff)
	);
	vic_core_model core (
		.pclk(pclk), .presetn(presetn), .irq_req_ff(irq_req_ff), .ack_en(ack_en),
		.ack_delay(ack_delay), .cpu_ack_ff(cpu_ack)
	);

	always #5 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////////
	// Compare, verdict and bus tasks
	task chk(input [31:0] got, input [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checks=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Request held until pready is seen high; error flag kept in bit 31
	task apb(input [11:0] a, input [31:0] d, input w);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwdata <= d;
		pwrite <= w;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready_ff !== 1'b1) @(posedge pclk);
		r = {pslverr_ff, prdata_ff[30:0]};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input [11:0] a, input [31:0] d);
		apb(a, d, 1'b1);
	endtask
	task rd(input [11:0] a, input [31:0] e);
		apb(a, '0, 1'b0);
		chk(r, e);
	endtask
	task pulse(input [127:0] p, input [4:0] e);
		@(posedge pclk);
		periph_irq <= p;
		evt <= e;
		@(posedge pclk);
		periph_irq <= '0;
		evt <= '0;
	endtask
	task pin(input [4:0] v);
		@(posedge pclk);
		ext_irq_pin <= v;
		idle(4);
	endtask
	task irq_chk(input [12:0] e);
		idle(4);
		chk({19'h0, irq_req_ff, irq_vector_ff, irq_level_ff}, {19'h0, e});
	endtask
	task nreq;
		idle(4);
		chk({31'h0, irq_req_ff}, 32'h0);
	endtask
	task trap_chk(input [8:0] e);
		idle(4);
		chk({23'h0, trap_req_ff, trap_vector_ff}, {23'h0, e});
	endtask

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register table first, then hand-written cases
	initial begin
		rows = '{{12'h000, 32'h0000FFFF, 32'h000000E0}, {12'h004, 32'h00000008, 32'h0},
			{12'h008, 32'h0000801E, 32'h0000801E}, {12'h000, 32'h0, 32'h000000E0},
			{12'h008, 32'h0, 32'h0}, {12'h000, 32'h0, 32'h0},
			{12'h00C, 32'h0000811F, 32'h0000811F}, {12'h00C, 32'h00008000, 32'h00008000},
			{12'h010, 32'h0000FFFF, 32'h0}, {12'h014, 32'h00002000, 32'h00002000},
			{12'h014, 32'h0, 32'h0}, {12'h040, 32'h0000FFFF, 32'h0},
			{12'h080, 32'h0000FFFF, 32'h00007777}, {12'h100, 32'h0000FFFF, 32'h80000000}};
		idle(5);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i][75:64], rows[i][63:32]);
			rd(rows[i][75:64], rows[i][31:0]);
		end
		// Equal priorities, slow acknowledge, held-off request
		wr(12'h080, 32'h0550);
		wr(12'h060, 32'h0006);
		pulse(128'h6, 5'h0);
		irq_chk(13'h1095);
		rd(12'h040, 32'h0006);
		ack_delay <= 4'h3;
		ack_en <= 1'b1;
		idle(10);
		ack_en <= 1'b0;
		nreq();
		rd(12'h000, 32'h00A0);
		rd(12'h014, 32'h8509);
		wr(12'h040, 32'h0004);
		rd(12'h040, 32'h0004);
		wr(12'h000, 32'h0);
		irq_chk(13'h10A5);
		// Nesting off: acknowledge lifts the level straight to 7
		wr(12'h008, 32'h8000);
		ack_delay <= 4'h0;
		ack_en <= 1'b1;
		idle(4);
		ack_en <= 1'b0;
		rd(12'h000, 32'h00E0);
		rd(12'h014, 32'h850A);
		wr(12'h008, 32'h0);
		wr(12'h000, 32'h0);
		irq_chk(13'h10A5);
		// Global disable blocks users, traps still flag
		wr(12'h00C, 32'h0);
		nreq();
		pulse('0, 5'b11110);
		trap_chk(9'h104);
		rd(12'h008, 32'h001E);
		rd(12'h004, 32'h0008);
		wr(12'h00C, 32'h8000);
		nreq();
		wr(12'h004, 32'h0);
		irq_chk(13'h10A5);
		wr(12'h014, 32'h2000);
		rd(12'h014, 32'h250A);
		wr(12'h014, 32'h0);
		wr(12'h060, 32'h0);
		nreq();
		rd(12'h040, 32'h0004);
		// Software trap and double bit error flags
		wr(12'h008, 32'h0);
		wr(12'h00C, 32'hA000);
		trap_chk(9'h106);
		rd(12'h010, 32'h0001);
		pulse('0, 5'b00001);
		rd(12'h010, 32'h0003);
		wr(12'h00C, 32'h8000);
		wr(12'h010, 32'h0);
		rd(12'h010, 32'h0);
		trap_chk(9'h000);
		wr(12'h004, 32'h0);
		// External pin edges under both polarities
		wr(12'h040, 32'h0);
		pin(5'h01);
		rd(12'h040, 32'h0001);
		wr(12'h040, 32'h0);
		pin(5'h00);
		rd(12'h040, 32'h0);
		wr(12'h00C, 32'h8001);
		pin(5'h01);
		rd(12'h040, 32'h0);
		pin(5'h00);
		rd(12'h040, 32'h0001);
		tda <= 1'b1;
		rd(12'h00C, 32'hC001);
		tda <= 1'b0;
		// Reset in mid-run restores control one, two and four, first flag and priority words and pending status
		wr(12'h00C, 32'h011F);
		idle(1);
		chk({31'h0, alt_table_ff}, 32'h1);
		wr(12'h008, 32'h8000);
		@(posedge pclk);
		presetn <= 1'b0;
		idle(2);
		presetn <= 1'b1;
		rd(12'h00C, 32'h8000);
		chk({31'h0, alt_table_ff}, 32'h0);
		rd(12'h008, 32'h0);
		rd(12'h040, 32'h0);
		rd(12'h080, 32'h0);
		rd(12'h014, 32'h0);
		rd(12'h010, 32'h0);
		stop_test();
	end
endmodule

// *** vic_checker_assertions.sv ***
// Checker of the interrupt controller's request, trap and table outputs.
// Assumes one pclk domain and presetn low while the design is in reset.
`timescale 1ns/1ps

module vic_checker (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready_ff,
	input wire math_fault_evt,
	input wire double_bit_error_evt,
	input wire cpu_ack,
	input wire irq_req_ff,
	input wire [7:0] irq_vector_ff,
	input wire [3:0] irq_level_ff,
	input wire trap_req_ff,
	input wire [7:0] trap_vector_ff,
	input wire alt_table_ff
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////
	// Offered request: accepted vector withdrawn, code ranges
	property p_ack_drop;
		cpu_ack && irq_req_ff |=> !irq_req_ff;
	endproperty
	a_ack_drop: assert property (p_ack_drop)
		else $error("request still offered after acknowledge");
	property p_level;
		irq_req_ff |-> irq_level_ff inside {[1:7]};
	endproperty
	a_level: assert property (p_level)
		else $error("offered level outside one to seven");
	property p_vector;
		irq_req_ff |-> irq_vector_ff inside {[8:135]};
	endproperty
	a_vector: assert property (p_vector)
		else $error("offered vector outside source range");

	////////////////////////////////////////////////////////////////////////
	// Traps: codes and bounded reaction to events
	property p_trap_vec;
		trap_req_ff |-> trap_vector_ff inside {8'h04, 8'h06};
	endproperty
	a_trap_vec: assert property (p_trap_vec)
		else $error("trap vector code wrong");
	property p_trap_idle;
		!trap_req_ff |-> trap_vector_ff == 8'h00;
	endproperty
	a_trap_idle: assert property (p_trap_idle)
		else $error("trap vector shown without trap");
	property p_math;
		math_fault_evt |-> ##[1:3] (trap_req_ff && trap_vector_ff == 8'h04);
	endproperty
	a_math: assert property (p_math)
		else $error("math event gave no math trap");
	property p_dbe;
		double_bit_error_evt |-> ##[1:3] trap_req_ff;
	endproperty
	a_dbe: assert property (p_dbe)
		else $error("double bit event gave no trap");

	////////////////////////////////////////////////////////////////////////
	// Table select follows the written control two bit
	property p_alt;
		psel && penable && pready_ff && pwrite && paddr == 12'h00C
			|=> alt_table_ff == $past(pwdata[8]);
	endproperty
	a_alt: assert property (p_alt)
		else $error("table select does not follow write");
endmodule

bind vectored_interrupt_controller vic_checker u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready_ff(pready_ff),
	.math_fault_evt(math_fault_evt), .double_bit_error_evt(double_bit_error_evt),
	.cpu_ack(cpu_ack), .irq_req_ff(irq_req_ff), .irq_vector_ff(irq_vector_ff),
	.irq_level_ff(irq_level_ff), .trap_req_ff(trap_req_ff),
	.trap_vector_ff(trap_vector_ff), .alt_table_ff(alt_table_ff)
);

// *** vic_core_model.sv ***
// Processor core model: acknowledges an offered vector after a delay.
// Assumes the bench sets ack_en and ack_delay; pulse lasts one cycle.
`timescale 1ns/1ps

module vic_core_model (
	input wire pclk,
	input wire presetn,
	input wire irq_req_ff,
	input wire ack_en,
	input wire [3:0] ack_delay,
	output reg cpu_ack_ff
);
	reg [3:0] wait_cnt_ff;

	// Wait while offered, then one pulse; dropped request restarts the wait
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt_ff <= 4'h0;
			cpu_ack_ff <= 1'b0;
		end else if (cpu_ack_ff) begin
			cpu_ack_ff <= 1'b0;
			wait_cnt_ff <= 4'h0;
		end else if (irq_req_ff && ack_en) begin
			if (wait_cnt_ff >= ack_delay)
				cpu_ack_ff <= 1'b1;
			else
				wait_cnt_ff <= wait_cnt_ff + 4'h1;
		end else begin
			wait_cnt_ff <= 4'h0;
		end
	end
endmodule

// *** vic_regs.vh ***
// Register map, field positions, reset values and codes of the vectored interrupt controller.
// Assumes a 12-bit APB byte address with one 32-bit aligned word per register.
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

// Sizes
`define NUM_SRC 128
`define SRC_IDX_W 7
`define PRIO_W 3
`define LVL_W 4
`define VEC_W 8
`define ADDR_W 12
`define NUM_EXT 5

// Byte addresses of the control registers
`define OFF_CPU_ALU_STATUS 12'h000
`define OFF_CPU_CORE_CONTROL 12'h004
`define OFF_IRQ_CONTROL_ONE 12'h008
`define OFF_IRQ_CONTROL_TWO 12'h00C
`define OFF_IRQ_CONTROL_FOUR 12'h010
`define OFF_PENDING_VECTOR_STATUS 12'h014
// Bases of the per-source register arrays
`define OFF_FLAG_BASE 12'h040
`define OFF_ENABLE_BASE 12'h060
`define OFF_PRIO_BASE 12'h080
`define NUM_FLAG_WORDS 12'h008
`define NUM_PRIO_WORDS 12'h020
`define SRC_PER_WORD 16
`define SRC_PER_PRIO_WORD 4

// cpu_alu_status fields
`define SR_LVL_LSB 5
`define SR_LVL_MSB 7
// cpu_core_control fields
`define CORE_LVL_HIGH_BIT 3
// irq_control_one fields
`define C1_NESTING_DISABLE 15
`define C1_MATH_FAULT 4
`define C1_ADDRESS_FAULT 3
`define C1_STACK_FAULT 2
`define C1_CLOCK_FAILURE 1
// irq_control_two fields
`define C2_GLOBAL_ENABLE 15
`define C2_TEMP_DISABLE 14
`define C2_SOFTWARE_TRAP 13
`define C2_ALT_TABLE 8
`define C2_POLARITY_MSB 4
// irq_control_four fields
`define C4_DOUBLE_BIT_ERROR 1
`define C4_SOFT_HARD_TRAP 0
// pending_vector_status fields
`define PV_UNACKED 15
`define PV_VECTOR_HOLD 13
`define PV_LEVEL_LSB 8

// Reset values
`define RST_GLOBAL_ENABLE 1'b1
`define RST_LEVEL 3'h0
`define RST_PRIO 3'h0

// Level and vector codes
`define LVL_USER_BLOCK 3'h7
`define VEC_USER_BASE 8'h08
`define VEC_MATH_TRAP 8'h04
`define VEC_SOFT_TRAP 8'h06
`define VEC_NONE 8'h00

// Source positions of external interrupts 4..0, seven bits each
`define EXT_IRQ_MAP {7'h36, 7'h35, 7'h1D, 7'h14, 7'h00}

`endif
